//--- verilog/rx_packet_buffer_fifo.sv
// Receive packet buffer: path set-up, record builder, access FIFO and AXI4-Lite slave
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "rx_buf_defs.svh"
module rx_packet_buffer_fifo #(
  parameter int NUM_DEMOD = `NUM_DEMOD,
  parameter int DW = $clog2(`NUM_DEMOD)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Decoded packet from the demodulators, same clock
  input wire logic rx_start,
  input wire logic [3:0] rx_channel,
  input wire logic [3:0] rx_spreading_factor,
  input wire logic [2:0] rx_coding_rate_field,
  input wire logic rx_crc_en,
  input wire logic [7:0] rx_len,
  input wire logic [31:0] rx_quality,
  input wire logic [15:0] rx_crc,
  input wire logic [DW-1:0] rx_demodulator_index,
  input wire logic [15:0] rx_correlation_peak_position,
  input wire logic [7:0] rx_detection_correlation_quality,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_byte_ready,
  output logic rx_idle,
  // Path set-up towards the demodulators
  output logic [9:0] path_enable,
  output logic [9:0] path_radio_b,
  output logic [199:0] path_if_freq,
  output logic [1:0] sr_bandwidth,
  output logic [3:0] sr_spreading_factor,
  output logic [1:0] mr_bandwidth,
  output logic [15:0] fsk_bit_rate,
  output logic [7:0] fsk_bandwidth
);
  import rx_buf_pkg::*;
  localparam logic [10:0] MEM_SIZE = 11'(`MEM_BYTES);
  localparam logic [4:0] META_LAST = 5'(`META_BYTES - 1);
  localparam logic [4:0] TAG_LAST = 5'(`TAG_STEP_CYCLES - 1);

  store_if st();
  packet_store u_store (.core_clk(core_clk), .st(st));
  access_fifo u_fifo (.core_clk(core_clk), .rst_n(rst_n), .st(st));

  // ----------------------------------------------------------------
  // Configuration and host pointer registers
  // ----------------------------------------------------------------
  logic [31:0] path_cfg_reg;
  logic [31:0] sr_cfg_reg;
  logic [31:0] fsk_cfg_reg;
  logic [19:0] if_reg [`NUM_PATHS];
  logic [9:0] host_ptr_reg;
  logic [7:0] drop_reg;
  entry_t cur_reg;
  logic cur_valid_reg;
  logic [10:0] used_reg;
  logic [31:0] tag_reg;
  logic [4:0] tick_reg;

  assign path_enable = path_cfg_reg[9:0];
  assign path_radio_b = path_cfg_reg[`PATH_RADIO_LSB +: 10];
  assign sr_bandwidth = sr_cfg_reg[1:0];
  assign sr_spreading_factor = sr_cfg_reg[`SR_SF_LSB +: 4];
  assign mr_bandwidth = `MR_BW_125K;
  assign fsk_bit_rate = fsk_cfg_reg[15:0];
  assign fsk_bandwidth = fsk_cfg_reg[`FSK_BW_LSB +: 8];

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_PATHS; gi++)
    begin : g_if
      assign path_if_freq[gi*20 +: 20] = if_reg[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Record builder
  // ----------------------------------------------------------------
  wr_state_t st_reg;
  logic keep_reg;
  logic [9:0] wptr_reg;
  logic [9:0] seg_reg;
  logic [7:0] len_reg;
  logic [7:0] pcnt_reg;
  logic [4:0] mcnt_reg;
  logic [143:0] meta_reg;

  // Single-rate path listens to one factor only; multi-rate paths take all
  wire sf_ok = (rx_channel != `SR_PATH_NUM) ||
    (rx_spreading_factor == sr_spreading_factor);
  wire ch_ok = (rx_channel >= 4'h1) && (rx_channel <= 4'hA) && path_enable[rx_channel - 4'h1];
  wire dm_ok = 32'(rx_demodulator_index) < NUM_DEMOD;
  wire [10:0] seg_len = 11'(rx_len) + 11'(`META_BYTES);
  wire room_ok = !st.full && (seg_len <= MEM_SIZE - used_reg);
  wire accept = rx_start && (st_reg == W_IDLE) && sf_ok && ch_ok && dm_ok && room_ok;
  wire [143:0] meta_new = {16'h0000, rx_detection_correlation_quality,
    rx_correlation_peak_position, 8'(rx_demodulator_index), rx_crc, tag_reg, rx_quality,
    rx_spreading_factor, rx_coding_rate_field, rx_crc_en, 4'h0, rx_channel};
  wire pay_take = (st_reg == W_PAY) && rx_byte_valid;

  assign rx_byte_ready = (st_reg == W_PAY);
  assign rx_idle = (st_reg == W_IDLE);
  assign st.mem_we = keep_reg && (pay_take || st_reg == W_META);
  assign st.mem_waddr = wptr_reg;
  assign st.mem_wdata = (st_reg == W_PAY) ? rx_byte : meta_reg[mcnt_reg*8 +: 8];
  assign st.push = keep_reg && (st_reg == W_PUSH);
  assign st.din = '{start: seg_reg, len: len_reg};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= W_IDLE;
      keep_reg <= 1'b0;
      wptr_reg <= '0;
      seg_reg <= '0;
      len_reg <= '0;
      pcnt_reg <= '0;
      mcnt_reg <= '0;
      meta_reg <= '0;
    end
    else
    begin
      case (st_reg)
        W_IDLE:
        begin
          if (rx_start)
          begin
            // Refused packets still drain their bytes so the source never hangs
            keep_reg <= accept;
            seg_reg <= wptr_reg;
            len_reg <= rx_len;
            meta_reg <= meta_new;
            pcnt_reg <= '0;
            mcnt_reg <= '0;
            st_reg <= (rx_len == 8'h00) ? W_META : W_PAY;
          end
        end
        W_PAY:
        begin
          if (rx_byte_valid)
          begin
            wptr_reg <= wptr_reg + 10'(keep_reg);
            pcnt_reg <= pcnt_reg + 8'h01;
            if (pcnt_reg == len_reg - 8'h01)
            begin
              st_reg <= W_META;
            end
          end
        end
        W_META:
        begin
          wptr_reg <= wptr_reg + 10'(keep_reg);
          mcnt_reg <= mcnt_reg + 5'h01;
          if (mcnt_reg == META_LAST)
          begin
            st_reg <= W_PUSH;
          end
        end
        W_PUSH:
        begin
          st_reg <= W_IDLE;
        end
        default:
        begin
          st_reg <= W_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Microsecond time tag
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_reg <= '0;
      tag_reg <= '0;
    end
    else
    begin
      tick_reg <= (tick_reg == TAG_LAST) ? 5'h00 : tick_reg + 5'h01;
      tag_reg <= tag_reg + 32'(tick_reg == TAG_LAST);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire wr_full = (wstrb_reg == 4'hF);
  wire adv_req = wr_go && awaddr_reg == `OFS_CTRL && wstrb_reg[0] && wdata_reg[`CTRL_NEXT_BIT];
  wire adv = adv_req && !st.empty;
  wire data_rd = rd_go && (s_axi_araddr == `OFS_PKT_DATA);
  wire ptr_wr = wr_go && wr_full && (awaddr_reg == `OFS_HOST_PTR);
  wire wr_map = (awaddr_reg <= `OFS_IF_CFG) && (awaddr_reg[1:0] == 2'b00);
  wire rd_map = (s_axi_araddr <= `OFS_IF_CFG) && (s_axi_araddr[1:0] == 2'b00);
  wire [10:0] free_old = cur_valid_reg ? 11'(cur_reg.len) + 11'(`META_BYTES) : 11'h000;
  wire [3:0] if_idx = wdata_reg[`IF_IDX_LSB +: 4];

  assign st.pop = adv;
  assign st.mem_raddr = host_ptr_reg;

  // Register a new value only for full-word writes to keep fields coherent
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= '0;
      path_cfg_reg <= `PATH_CFG_RST;
      sr_cfg_reg <= `SR_CFG_RST;
      fsk_cfg_reg <= `FSK_CFG_RST;
      host_ptr_reg <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? 2'b00 : 2'b10;
        if (wr_full && awaddr_reg == `OFS_PATH_CFG)
          path_cfg_reg <= wdata_reg;
        if (wr_full && awaddr_reg == `OFS_SR_CFG)
          sr_cfg_reg <= wdata_reg;
        if (wr_full && awaddr_reg == `OFS_FSK_CFG)
          fsk_cfg_reg <= wdata_reg;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (ptr_wr)
      begin
        host_ptr_reg <= wdata_reg[9:0];
      end
      else if (data_rd)
      begin
        host_ptr_reg <= host_ptr_reg + 10'h001;
      end
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_map ? 2'b00 : 2'b10;
        case (s_axi_araddr)
          `OFS_STATUS: s_axi_rdata <= {16'h0000, drop_reg, 3'b000, st.count};
          `OFS_ENTRY: s_axi_rdata <= {cur_valid_reg, 7'h00, cur_reg.len, 6'h00, cur_reg.start};
          `OFS_HOST_PTR: s_axi_rdata <= {22'h000000, host_ptr_reg};
          `OFS_PKT_DATA: s_axi_rdata <= {24'h000000, st.mem_rdata};
          `OFS_PATH_CFG: s_axi_rdata <= path_cfg_reg;
          `OFS_SR_CFG: s_axi_rdata <= sr_cfg_reg;
          `OFS_FSK_CFG: s_axi_rdata <= fsk_cfg_reg;
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // IF table, drop counter, current entry and space in use
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `NUM_PATHS; i++)
        if_reg[i] <= '0;
      drop_reg <= '0;
      cur_reg <= '0;
      cur_valid_reg <= 1'b0;
      used_reg <= '0;
    end
    else
    begin
      if (wr_go && wr_full && awaddr_reg == `OFS_IF_CFG && if_idx < 4'hA)
        if_reg[if_idx] <= wdata_reg[19:0];
      if (rx_start && st_reg == W_IDLE && !accept && drop_reg != 8'hFF)
        drop_reg <= drop_reg + 8'h01;
      if (adv)
      begin
        cur_reg <= st.dout;
        cur_valid_reg <= 1'b1;
      end
      // Space is reserved at acceptance and returned when the host steps past it
      used_reg <= used_reg + (accept ? seg_len : 11'h000) - (adv ? free_old : 11'h000);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  fifo_bound_a: assert property (st.count <= 5'(`FIFO_DEPTH))
    else $error("access FIFO count above depth");
  // A push in the same cycle may still raise the count; the advance itself must not
  adv_empty_a: assert property (adv_req && st.empty |=> $stable(cur_reg) &&
    st.count == $past(st.count) + 5'($past(st.push)))
    else $error("advance on empty FIFO changed state");
  // A pointer load in the same cycle takes priority over the step
  ptr_step_a: assert property (data_rd && !ptr_wr |=>
    host_ptr_reg == $past(host_ptr_reg) + 10'h001)
    else $error("host pointer did not step after data read");
  push_start_a: assert property (accept |=>
    st.din.start == $past(wptr_reg) ##[1:275] st.push)
    else $error("pushed start differs from allocated segment");
  sr_filter_a: assert property (rx_start && rx_channel == `SR_PATH_NUM &&
    rx_spreading_factor != sr_spreading_factor |-> !accept)
    else $error("single-rate path took a packet at another rate");
  // The byte counter carries the run length, so only its end point is checked
  meta_run_a: assert property ($rose(st_reg == W_META) |->
    ##17 (st_reg == W_META && mcnt_reg == META_LAST) ##1 st_reg == W_PUSH)
    else $error("meta-data run not eighteen bytes");
  demod_lim_a: assert property (accept |-> 32'(rx_demodulator_index) < NUM_DEMOD)
    else $error("demodulator index out of range accepted");
  used_bound_a: assert property (used_reg <= MEM_SIZE)
    else $error("packet memory over-allocated");
  count_track_a: assert property (st.push && !adv |=> st.count == $past(st.count) + 5'h01)
    else $error("packet count missed a stored packet");

  store_cov: cover property (st.push);
  fetch_cov: cover property (adv ##[1:20] data_rd);
  full_cov: cover property (st.full);
endmodule
`default_nettype wire

//--- include/rx_buf_defs.svh
// Constants of the receive packet buffer: sizes, offsets, fields, resets, timing
`ifndef RX_BUF_DEFS_SVH
`define RX_BUF_DEFS_SVH
`define MEM_BYTES 1024
`define MEM_AW 10
`define FIFO_DEPTH 16
`define NUM_PATHS 10
`define NUM_DEMOD 8
`define META_BYTES 18
`define SR_PATH_NUM 4'h9
`define MR_BW_125K 2'h0
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_ENTRY 8'h08
`define OFS_HOST_PTR 8'h0C
`define OFS_PKT_DATA 8'h10
`define OFS_PATH_CFG 8'h14
`define OFS_SR_CFG 8'h18
`define OFS_FSK_CFG 8'h1C
`define OFS_IF_CFG 8'h20
// Field positions
`define CTRL_NEXT_BIT 0
`define PATH_RADIO_LSB 16
`define SR_SF_LSB 4
`define FSK_BW_LSB 16
`define IF_IDX_LSB 24
`define ENTRY_LEN_LSB 16
`define ENTRY_VALID_BIT 31
`define STATUS_DROP_LSB 8
// Reset values
`define PATH_CFG_RST 32'h0000_03FF
`define SR_CFG_RST 32'h0000_0070
`define FSK_CFG_RST 32'h0000_0000
// Timing: microsecond time tag at a 50 ns clock
`define CLK_PERIOD_NS 50
`define TAG_STEP_NS 1000
`define TAG_STEP_CYCLES (`TAG_STEP_NS / `CLK_PERIOD_NS)
`endif

//--- include/rx_buf_pkg.sv
// Types shared by the receive packet buffer modules
package rx_buf_pkg;
  typedef enum logic [3:0] {
    W_IDLE = 4'b0001,
    W_PAY = 4'b0010,
    W_META = 4'b0100,
    W_PUSH = 4'b1000
  } wr_state_t;
  typedef struct packed {
    logic [9:0] start;
    logic [7:0] len;
  } entry_t;
endpackage

//--- include/store_if.sv
// Bundle between the buffer controller, the packet memory and the access FIFO
`timescale 1ns/10ps
`default_nettype none
interface store_if;
  import rx_buf_pkg::*;
  logic mem_we;
  logic [9:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [9:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic push;
  logic pop;
  entry_t din;
  entry_t dout;
  logic [4:0] count;
  logic full;
  logic empty;
  modport ctrl(output mem_we, mem_waddr, mem_wdata, mem_raddr, push, pop, din,
    input mem_rdata, dout, count, full, empty);
  modport mem(input mem_we, mem_waddr, mem_wdata, mem_raddr, output mem_rdata);
  modport fifo(input push, pop, din, output dout, count, full, empty);
endinterface
`default_nettype wire

//--- verilog/packet_store.sv
// Shared packet memory, byte wide, one write and one read port
`timescale 1ns/10ps
`default_nettype none
`include "rx_buf_defs.svh"
module packet_store #(
  parameter int BYTES = `MEM_BYTES
) (
  // Clock
  input wire logic core_clk,
  // Controller side
  store_if.mem st
);
  import rx_buf_pkg::*;
  logic [7:0] mem [BYTES];

  always_ff @(posedge core_clk)
  begin
    if (st.mem_we)
    begin
      mem[st.mem_waddr] <= st.mem_wdata;
    end
  end

  // Read is combinational; the controller registers the byte on the bus
  assign st.mem_rdata = mem[st.mem_raddr];
endmodule
`default_nettype wire

//--- verilog/access_fifo.sv
// Access FIFO of (start, length) pairs
`timescale 1ns/10ps
`default_nettype none
`include "rx_buf_defs.svh"
module access_fifo #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Controller side
  store_if.fifo st
);
  import rx_buf_pkg::*;
  localparam int PW = $clog2(DEPTH);
  entry_t ent [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [4:0] cnt_reg;
  wire do_push = st.push && !st.full;
  wire do_pop = st.pop && !st.empty;

  always_ff @(posedge core_clk)
  begin
    if (do_push)
    begin
      ent[wr_reg] <= st.din;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_reg + PW'(do_push);
      rd_reg <= rd_reg + PW'(do_pop);
      cnt_reg <= cnt_reg + 5'(do_push) - 5'(do_pop);
    end
  end

  assign st.dout = ent[rd_reg];
  assign st.count = cnt_reg;
  assign st.full = (cnt_reg == 5'(DEPTH));
  assign st.empty = (cnt_reg == 5'h0);
endmodule
`default_nettype wire

//--- verification/rx_source_model.sv
// Demodulator side model: header pulse, then a payload stream that stalls
`timescale 1ns/10ps
`default_nettype none
module rx_source_model (
  // Clock and handshake
  input wire logic core_clk,
  input wire logic rx_byte_ready,
  input wire logic rx_idle,
  // Packet towards the buffer
  output logic rx_start,
  output logic [3:0] rx_channel,
  output logic [3:0] rx_spreading_factor,
  output logic [2:0] rx_coding_rate_field,
  output logic rx_crc_en,
  output logic [7:0] rx_len,
  output logic [31:0] rx_quality,
  output logic [15:0] rx_crc,
  output logic [2:0] rx_demodulator_index,
  output logic [15:0] rx_correlation_peak_position,
  output logic [7:0] rx_detection_correlation_quality,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte
);
  initial
  begin
    {rx_start, rx_channel, rx_spreading_factor, rx_len, rx_byte_valid} = '0;
    rx_byte = 8'h00;
    rx_coding_rate_field = 3'h5;
    rx_crc_en = 1'b1;
    rx_quality = 32'h4433_2211;
    rx_crc = 16'hBEEF;
    rx_demodulator_index = 3'h2;
    rx_correlation_peak_position = 16'h5A6B;
    rx_detection_correlation_quality = 8'h77;
  end
  // Payload byte i is base+i; every other cycle is a stall
  task automatic send(input logic [3:0] ch, input logic [3:0] sf, input logic [7:0] len,
    input logic [7:0] base);
    int i;
    int n;
    logic s;
    i = 0;
    n = 0;
    s = 1'b0;
    while (rx_idle !== 1'b1 && n < 1000)
    begin
      @(posedge core_clk);
      n++;
    end
    rx_start <= 1'b1;
    rx_channel <= ch;
    rx_spreading_factor <= sf;
    rx_len <= len;
    @(posedge core_clk);
    rx_start <= 1'b0;
    while (i < len && n < 2000)
    begin
      rx_byte_valid <= s;
      // Released line shows the inverse so a stale byte never matches
      rx_byte <= s ? base + 8'(i) : ~(base + 8'(i));
      s = !s;
      @(posedge core_clk);
      n++;
      if (rx_byte_valid && rx_byte_ready === 1'b1)
        i++;
    end
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
  endtask
endmodule
`default_nettype wire

//--- verification/test_rx_packet_buffer_fifo.sv
// Self-checking bench of the receive packet buffer over AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
`include "rx_buf_defs.svh"
module test_rx_packet_buffer_fifo;
  import rx_buf_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp, sr_bandwidth, mr_bandwidth;
  wire logic [31:0] s_axi_rdata, rx_quality;
  wire logic rx_start, rx_crc_en, rx_byte_valid, rx_byte_ready, rx_idle;
  wire logic [3:0] rx_channel, rx_spreading_factor, sr_spreading_factor;
  wire logic [2:0] rx_coding_rate_field, rx_demodulator_index;
  wire logic [7:0] rx_len, rx_byte, rx_detection_correlation_quality, fsk_bandwidth;
  wire logic [15:0] rx_crc, rx_correlation_peak_position, fsk_bit_rate;
  wire logic [9:0] path_enable, path_radio_b;
  wire logic [199:0] path_if_freq;
  int fails = 0;
  int checked = 0;
  logic [31:0] rd;
  logic [1:0] rsp;

  initial
  begin
    forever #25 core_clk = ~core_clk;
  end

  rx_packet_buffer_fifo rx_packet_buffer_fifo_i (.*);
  rx_source_model rx_source_model_i (.*);

  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_d;
    logic w_d;
    aw_d = 0;
    w_d = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
      begin
        aw_d = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1)
      begin
        w_d = 1;
        s_axi_wvalid <= 0;
      end
    end while (!(aw_d && w_d));
    while (s_axi_bvalid !== 1'b1)
      @(posedge core_clk);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge core_clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
      @(posedge core_clk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1)
      @(posedge core_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge core_clk);
  endtask

  // Push lands on the edge where the builder goes idle; the two further edges are margin
  task automatic settle();
    do
      @(posedge core_clk);
    while (rx_idle !== 1'b1);
    repeat (2) @(posedge core_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    axi_rd(`OFS_PATH_CFG, rd, rsp);
    chk("path_cfg", `PATH_CFG_RST, rd);
    chk("path_enable", 32'h3FF, 32'(path_enable));
    axi_rd(`OFS_SR_CFG, rd, rsp);
    chk("sr_cfg", `SR_CFG_RST, rd);
    chk("mr_bandwidth", 32'(`MR_BW_125K), 32'(mr_bandwidth));
  endtask

  task automatic t_config();
    axi_wr(`OFS_FSK_CFG, 32'h0012_3456, rsp);
    chk("write ok", 32'h0, 32'(rsp));
    chk("fsk_bit_rate", 32'h3456, 32'(fsk_bit_rate));
    chk("fsk_bandwidth", 32'h12, 32'(fsk_bandwidth));
    axi_wr(`OFS_IF_CFG, 32'h0300_ABCD, rsp);
    chk("path3 if", 32'h0_ABCD, 32'(path_if_freq[60 +: 20]));
    axi_wr(`OFS_PATH_CFG, 32'h0200_03FF, rsp);
    chk("path_radio_b", 32'h200, 32'(path_radio_b));
    chk("path_enable kept", 32'h3FF, 32'(path_enable));
  endtask

  task automatic t_empty_advance();
    axi_wr(`OFS_CTRL, 32'h1, rsp);
    axi_rd(`OFS_STATUS, rd, rsp);
    chk("status empty", 32'h0, rd);
    axi_rd(`OFS_ENTRY, rd, rsp);
    chk("entry valid", 32'h0, 32'(rd[31]));
  endtask

  // Two packets back to back; second segment starts after len+18 bytes
  task automatic t_packets();
    logic [7:0] e [19];
    e = '{8'hA0, 8'hA1, 8'hA2, 8'h01, 8'h9B, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00,
      8'h00, 8'h00, 8'h00, 8'hEF, 8'hBE, 8'h02, 8'h6B, 8'h5A, 8'h77};
    rx_source_model_i.send(4'h1, 4'h9, 8'h03, 8'hA0);
    rx_source_model_i.send(4'hA, 4'h7, 8'h00, 8'h00);
    settle();
    axi_rd(`OFS_STATUS, rd, rsp);
    chk("status count", 32'h2, 32'(rd[4:0]));
    axi_wr(`OFS_CTRL, 32'h1, rsp);
    axi_rd(`OFS_ENTRY, rd, rsp);
    chk("entry first", 32'h8003_0000, rd);
    axi_wr(`OFS_HOST_PTR, 32'h0, rsp);
    for (int i = 0; i < 19; i++)
    begin
      axi_rd(`OFS_PKT_DATA, rd, rsp);
      if (i < 9 || i > 12)
        chk("record byte", 32'(e[i]), 32'(rd[7:0]));
    end
    axi_rd(`OFS_HOST_PTR, rd, rsp);
    chk("host_ptr", 32'h13, rd);
    axi_wr(`OFS_CTRL, 32'h1, rsp);
    axi_rd(`OFS_ENTRY, rd, rsp);
    chk("entry second", 32'h8000_0015, rd);
    axi_rd(`OFS_STATUS, rd, rsp);
    chk("status drained", 32'h0, 32'(rd[4:0]));
  endtask

  // Ends with a short fetch of payload plus channel and rate bytes only
  task automatic t_single_rate();
    logic [7:0] e [3];
    e = '{8'h10, 8'h09, 8'h8B};
    rx_source_model_i.send(4'h9, 4'h8, 8'h01, 8'h10);
    settle();
    axi_rd(`OFS_STATUS, rd, rsp);
    chk("refused", 32'h0000_0100, rd);
    axi_wr(`OFS_SR_CFG, 32'h0000_0082, rsp);
    chk("sr factor", 32'h8, 32'(sr_spreading_factor));
    chk("sr bandwidth", 32'h2, 32'(sr_bandwidth));
    rx_source_model_i.send(4'h9, 4'h8, 8'h01, 8'h10);
    settle();
    axi_rd(`OFS_STATUS, rd, rsp);
    chk("accepted", 32'h0000_0101, rd);
    axi_wr(`OFS_CTRL, 32'h1, rsp);
    axi_rd(`OFS_ENTRY, rd, rsp);
    chk("entry third", 32'h8001_0027, rd);
    axi_wr(`OFS_HOST_PTR, 32'h27, rsp);
    for (int i = 0; i < 3; i++)
    begin
      axi_rd(`OFS_PKT_DATA, rd, rsp);
      chk("short read", 32'(e[i]), 32'(rd[7:0]));
    end
  endtask

  task automatic t_unmapped();
    axi_wr(8'h40, 32'h1234_5678, rsp);
    chk("write resp", 32'h2, 32'(rsp));
    axi_rd(8'h40, rd, rsp);
    chk("read resp", 32'h2, 32'(rsp));
  endtask

  task automatic complete_run();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #2_000_000;
    fails++;
    complete_run();
  end

  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_config();
    t_empty_advance();
    t_packets();
    t_single_rate();
    t_unmapped();
    complete_run();
  end
endmodule
`default_nettype wire
